/* File: logic/sit_target.sv */
// Two-wire serial target of a humidity and temperature sensor: bus framing,
// command intake, busy and result bookkeeping, checksummed read-out.
// Assumes an analog front end on mclk that answers meas_start with
// meas_done and the two raw words, and an open-drain SDA resolved outside.
//
// What this block does
// - Both lines released and high means bus free; the target stays idle.
// - SDA falling while SCL high is a start; target then treats bus as busy.
// - SDA rising while SCL high is a stop; target returns to idle.
// - A repeated start acts exactly like a start and restarts address reception.
// - SDA changes only while SCL low; bits are sampled on SCL rising.
// - Every byte is eight bits, most significant bit first.
// - Ninth pulse carries acknowledge; accepting receiver holds SDA low.
// - Refusing receiver leaves SDA high; controller then stops or restarts.
// - First byte after start is seven address bits plus direction bit.
// - Target answers only its own fixed address and ignores others.
// - Direction zero is a write, direction one is a read.
// - A write is address header then one command byte, framed by start and stop.
// - With a finished result, a read header is acknowledged and bytes follow.
// - Read-out is temperature word, its CRC, humidity word, its CRC.
// - The first acknowledged read header invalidates the stored result.
// - The target never holds SCL low.
// - A read header during measurement or heating is not acknowledged.
// - The controller may stop after any data word; target copes cleanly.
// - Checksum is CRC-8, polynomial 0x31, initial 0xff, no reflection.
// - Lines are only pulled low or released, never driven high.
// - Commands fd, f6, e0 start measurements of high, medium, low repeatability.
// - Heater commands heat then measure at high repeatability, same format.
`default_nettype none

module sit_target
  import sit_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `SIT_ADDR
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        link_clk,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             meas_start,
  output logic [7:0]       meas_cmd,
  output logic             meas_heat,
  input  wire logic        meas_done,
  input  wire logic [15:0] meas_temp,
  input  wire logic [15:0] meas_hum,
  output logic             busy,
  output logic             result_valid
);

  // -----------------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------------
  if (TARGET_ADDR[6:3] == 4'h0 || TARGET_ADDR[6:3] == 4'hf) begin : g_bad_addr
    $error("Target address lies in a reserved address group.");
  end
  if ($bits(sit_result_t) != 48) begin : g_bad_frame
    $error("The read-out frame must hold exactly six bytes.");
  end
  if (`SIT_BITS != 4'h8 || `SIT_LAST_BYTE != 3'h5) begin : g_bad_framing
    $error("Byte framing constants do not fit the shifters.");
  end

  // -----------------------------------------------------------------------
  // Link-domain reset: asserted at once, released on link_clk
  // -----------------------------------------------------------------------
  logic link_rst_q1;
  logic link_rst_n;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_rst_q1 <= 1'b0;
      link_rst_n  <= 1'b0;
    end else begin
      link_rst_q1 <= 1'b1;
      link_rst_n  <= link_rst_q1;
    end
  end

  // -----------------------------------------------------------------------
  // Pin synchronisers and line events on link_clk
  // -----------------------------------------------------------------------
  logic [2:0] scl_q;
  logic [2:0] sda_q;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  // Start and stop are read from two successive synchronised samples, so the
  // link clock must sample each SCL high and low period several times.
  wire scl      = scl_q[1];
  wire sda      = sda_q[1];
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_ev = scl & scl_q[2] & ~sda & sda_q[2];
  wire stop_ev  = scl & scl_q[2] & sda & ~sda_q[2];

  // -----------------------------------------------------------------------
  // Crossings from mclk into the link domain
  // -----------------------------------------------------------------------
  logic        res_tgl;
  logic        rd_tgl;
  logic        cmd_tgl;
  logic [7:0]  cmd_byte;
  sit_result_t result;
  logic [2:0]  res_tgl_q;
  logic [1:0]  busy_q;
  logic [1:0]  valid_q;
  sit_result_t frame;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      res_tgl_q <= 3'h0;
    end else begin
      res_tgl_q <= {res_tgl_q[1:0], res_tgl};
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      busy_q    <= 2'h0;
      valid_q   <= 2'h0;
    end else begin
      busy_q    <= {busy_q[0], busy};
      valid_q   <= {valid_q[0], result_valid};
    end
  end

  // The result words stay still from their toggle until the next
  // measurement ends, so a copy on the synchronised edge is safe.
  wire res_arrived = res_tgl_q[2] ^ res_tgl_q[1];

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frame <= '0;
    end else if (res_arrived) begin
      frame <= result;
    end
  end

  wire busy_l    = busy_q[1];
  wire read_ok   = valid_q[1] & ~busy_l;

  // -----------------------------------------------------------------------
  // Byte decode
  // -----------------------------------------------------------------------
  logic [7:0] rx_sh;
  wire        addr_hit  = (rx_sh[7:1] == TARGET_ADDR);
  wire        dir_read  = (rx_sh[0] == `SIT_DIR_READ);
  wire        cmd_meas  = (rx_sh == `SIT_CMD_MEAS_HI) |
                          (rx_sh == `SIT_CMD_MEAS_MED) |
                          (rx_sh == `SIT_CMD_MEAS_LO);
  wire        cmd_heat  = (rx_sh == `SIT_CMD_HEAT_0) | (rx_sh == `SIT_CMD_HEAT_1) |
                          (rx_sh == `SIT_CMD_HEAT_2) | (rx_sh == `SIT_CMD_HEAT_3) |
                          (rx_sh == `SIT_CMD_HEAT_4) | (rx_sh == `SIT_CMD_HEAT_5);
  wire        cmd_ok    = (cmd_meas | cmd_heat) & ~busy_l;

  // -----------------------------------------------------------------------
  // Link state machine
  // -----------------------------------------------------------------------
  sit_state_t  state;
  logic [3:0]  bit_cnt;
  logic [2:0]  byte_idx;
  logic [7:0]  tx_sh;
  logic        mack_nak;
  logic        drive_low;

  // Read-out bytes in the order they leave the pin; the two spare slots read
  // as a released line, so an index past the frame never pulls SDA low.
  wire  [7:0]  frame_byte [8];
  assign frame_byte[0] = frame.temp_word[15:8];
  assign frame_byte[1] = frame.temp_word[7:0];
  assign frame_byte[2] = frame.temp_crc;
  assign frame_byte[3] = frame.hum_word[15:8];
  assign frame_byte[4] = frame.hum_word[7:0];
  assign frame_byte[5] = frame.hum_crc;
  assign frame_byte[6] = 8'hff;
  assign frame_byte[7] = 8'hff;
  wire  [2:0]  sel_idx    = byte_idx + 3'h1;
  wire  [7:0]  next_byte  = frame_byte[sel_idx];
  wire         last_bit   = (bit_cnt == `SIT_BITS);

  // Decisions taken at the SCL fall that closes the eighth bit of a byte.
  wire         byte_end   = scl_fall & last_bit;
  wire         take_wr    = (state == SIT_ADDR) & addr_hit & ~dir_read;
  wire         take_rd    = (state == SIT_ADDR) & addr_hit & dir_read & read_ok;
  wire         take_cmd   = (state == SIT_CMD) & cmd_ok;
  wire         frame_end  = (byte_idx == `SIT_LAST_BYTE);

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state     <= SIT_IDLE;
      bit_cnt   <= 4'h0;
      byte_idx  <= 3'h0;
      rx_sh     <= 8'h00;
      tx_sh     <= 8'hff;
      mack_nak  <= 1'b1;
      drive_low <= 1'b0;
      rd_tgl    <= 1'b0;
      cmd_tgl   <= 1'b0;
      cmd_byte  <= 8'h00;
    end else if (stop_ev) begin
      state     <= SIT_IDLE;
      drive_low <= 1'b0;
    end else if (start_ev) begin
      state     <= SIT_ADDR;
      bit_cnt   <= 4'h0;
      drive_low <= 1'b0;
    end else begin
      unique case (state)
        SIT_IDLE, SIT_SKIP: begin
          drive_low <= 1'b0;
        end
        SIT_ADDR, SIT_CMD: begin
          if (scl_rise) begin
            rx_sh   <= {rx_sh[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            if (take_wr) begin
              drive_low <= 1'b1;
              state     <= SIT_AACK;
            end else if (take_rd) begin
              drive_low <= 1'b1;
              rd_tgl    <= ~rd_tgl;
              byte_idx  <= 3'h0;
              state     <= SIT_AACK;
            end else if (take_cmd) begin
              drive_low <= 1'b1;
              cmd_byte  <= rx_sh;
              cmd_tgl   <= ~cmd_tgl;
              state     <= SIT_CACK;
            end else begin
              state     <= SIT_SKIP;
            end
          end
        end
        SIT_AACK: begin
          if (scl_fall && !rx_sh[0]) begin
            drive_low <= 1'b0;
            bit_cnt   <= 4'h0;
            state     <= SIT_CMD;
          end else if (scl_fall) begin
            drive_low <= ~frame_byte[0][7];
            tx_sh     <= {frame_byte[0][6:0], 1'b1};
            bit_cnt   <= 4'h1;
            state     <= SIT_TX;
          end
        end
        SIT_CACK: begin
          if (scl_fall) begin
            drive_low <= 1'b0;
            state     <= SIT_SKIP;
          end
        end
        SIT_TX: begin
          if (scl_fall && last_bit) begin
            drive_low <= 1'b0;
            state     <= SIT_MACK;
          end else if (scl_fall) begin
            drive_low <= ~tx_sh[7];
            tx_sh     <= {tx_sh[6:0], 1'b1};
            bit_cnt   <= bit_cnt + 4'h1;
          end
        end
        SIT_MACK: begin
          // The controller's answer is taken at the rise and acted on at the
          // fall, so a stop after any word finds SDA already released.
          if (scl_rise) begin
            mack_nak <= sda;
          end else if (scl_fall && (mack_nak || frame_end)) begin
            state    <= SIT_SKIP;
          end else if (scl_fall) begin
            drive_low <= ~next_byte[7];
            tx_sh     <= {next_byte[6:0], 1'b1};
            bit_cnt   <= 4'h1;
            byte_idx  <= byte_idx + 3'h1;
            state     <= SIT_TX;
          end
        end
      endcase
    end
  end

  // Open drain: the data line is only ever pulled low, and SCL is never
  // driven, so the controller alone times the bus.
  assign sda_o  = 1'b0;
  assign sda_oe = drive_low;

  // -----------------------------------------------------------------------
  // Crossings from the link domain into mclk
  // -----------------------------------------------------------------------
  logic [2:0] cmd_tgl_q;
  logic [2:0] rd_tgl_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_tgl_q <= 3'h0;
    end else begin
      cmd_tgl_q <= {cmd_tgl_q[1:0], cmd_tgl};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_tgl_q  <= 3'h0;
    end else begin
      rd_tgl_q  <= {rd_tgl_q[1:0], rd_tgl};
    end
  end

  // cmd_byte changes on the same link edge as its toggle and then holds; the
  // synchroniser stages give it time to settle before mclk reads it.
  wire cmd_ev  = cmd_tgl_q[2] ^ cmd_tgl_q[1];
  wire rd_ev   = rd_tgl_q[2] ^ rd_tgl_q[1];
  wire heat_ev = cmd_byte != `SIT_CMD_MEAS_HI && cmd_byte != `SIT_CMD_MEAS_MED &&
                 cmd_byte != `SIT_CMD_MEAS_LO;
  wire accept_cmd = cmd_ev & ~busy;
  wire store_res  = meas_done & busy;

  // -----------------------------------------------------------------------
  // Measurement bookkeeping on mclk
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meas_start <= 1'b0;
      meas_cmd   <= 8'h00;
      meas_heat  <= 1'b0;
      busy       <= 1'b0;
    end else begin
      meas_start <= accept_cmd;
      if (accept_cmd) begin
        meas_cmd  <= cmd_byte;
        meas_heat <= heat_ev;
      end
      // A command that lands together with a stray finish still marks the
      // target busy: the set wins, or the new measurement would run unseen.
      if (accept_cmd) begin
        busy <= 1'b1;
      end else if (meas_done) begin
        busy <= 1'b0;
      end
    end
  end

  // A finished measurement in the same cycle as a read header invalidating
  // the old one keeps the new result: the set wins.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result_valid <= 1'b0;
      result       <= '0;
      res_tgl      <= 1'b0;
    end else if (store_res) begin
      result.temp_word <= meas_temp;
      result.temp_crc  <= sit_crc8(meas_temp);
      result.hum_word  <= meas_hum;
      result.hum_crc   <= sit_crc8(meas_hum);
      result_valid     <= 1'b1;
      res_tgl          <= ~res_tgl;
    end else if (rd_ev) begin
      result_valid     <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: logic/sit_cfg.svh */
// Constants of the sensor two-wire target: address, command codes, CRC
// parameters and read-out framing.
// Assumes nothing; included by the package and by the test bench.
`ifndef SIT_CFG_SVH
`define SIT_CFG_SVH

// -----------------------------------------------------------------------
// Bus addressing
// -----------------------------------------------------------------------
`define SIT_ADDR         7'h44
`define SIT_DIR_WRITE    1'b0
`define SIT_DIR_READ     1'b1

// -----------------------------------------------------------------------
// Command bytes
// -----------------------------------------------------------------------
`define SIT_CMD_MEAS_HI  8'hfd
`define SIT_CMD_MEAS_MED 8'hf6
`define SIT_CMD_MEAS_LO  8'he0
`define SIT_CMD_HEAT_0   8'h39
`define SIT_CMD_HEAT_1   8'h32
`define SIT_CMD_HEAT_2   8'h2f
`define SIT_CMD_HEAT_3   8'h24
`define SIT_CMD_HEAT_4   8'h1e
`define SIT_CMD_HEAT_5   8'h15

// -----------------------------------------------------------------------
// Checksum and framing
// -----------------------------------------------------------------------
`define SIT_CRC_POLY     8'h31
`define SIT_CRC_INIT     8'hff
`define SIT_CRC_XOROUT   8'h00
`define SIT_BITS         4'h8
`define SIT_LAST_BYTE    3'h5

`endif

/* File: logic/sit_pkg.sv */
// Types and the checksum function shared by the sensor two-wire target.
// Assumes sit_cfg.svh is on the include path.
`include "sit_cfg.svh"
`default_nettype none

package sit_pkg;

  // Link state machine, Gray coded along address, command and read paths.
  typedef enum logic [2:0] {
    SIT_IDLE = 3'b000,
    SIT_ADDR = 3'b001,
    SIT_AACK = 3'b011,
    SIT_CMD  = 3'b010,
    SIT_CACK = 3'b110,
    SIT_TX   = 3'b111,
    SIT_MACK = 3'b101,
    SIT_SKIP = 3'b100
  } sit_state_t;

  // One complete read-out frame, sent from temp_word down to hum_crc.
  typedef struct packed {
    logic [15:0] temp_word;
    logic [7:0]  temp_crc;
    logic [15:0] hum_word;
    logic [7:0]  hum_crc;
  } sit_result_t;

  // CRC-8, MSB first, not reflected.
  function automatic logic [7:0] sit_crc8(input logic [15:0] word);
    logic [7:0] crc;
    crc = `SIT_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc[7] ^ word[i]) begin
        crc = {crc[6:0], 1'b0} ^ `SIT_CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc ^ `SIT_CRC_XOROUT;
  endfunction

endpackage

`default_nettype wire

/* File: test/sit_target_props.sv */
// Concurrent checks on the sensor two-wire target, seen from its ports only.
// Assumes it is bound to sit_target; link checks run on link_clk, the rest on mclk.
`default_nettype none
module sit_target_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        link_clk,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        meas_start,
  input wire logic [7:0]  meas_cmd,
  input wire logic        meas_heat,
  input wire logic        meas_done,
  input wire logic [15:0] meas_temp,
  input wire logic [15:0] meas_hum,
  input wire logic        busy,
  input wire logic        result_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Link and measurement checks
  // ---------------------------------------------------------------
  a_drain_only: assert property (@(posedge link_clk) disable iff (!reset_n)
    !sda_o) else $error("sda driven high");
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(sda_oe) |-> !scl_i) else $error("sda moved while scl high");
  a_ack_held: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(scl_i) && sda_oe |-> sda_oe [*5]) else $error("low bit not held");
  a_busy_after_start: assert property (@(posedge mclk) disable iff (!reset_n)
    meas_start |-> ##[0:8] busy) else $error("no busy after start");
  a_cmd_known: assert property (@(posedge mclk) disable iff (!reset_n)
    meas_start |=> meas_cmd inside {8'hfd, 8'hf6, 8'he0, 8'h39, 8'h32, 8'h2f, 8'h24,
      8'h1e, 8'h15}) else $error("unknown command started");
  a_heat_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    meas_start |=> meas_heat == (meas_cmd inside {8'h39, 8'h32, 8'h2f, 8'h24, 8'h1e,
      8'h15})) else $error("heater flag wrong");
  a_done_stores: assert property (@(posedge mclk) disable iff (!reset_n)
    meas_done && busy |=> result_valid && !busy) else $error("result not stored");
  a_valid_drop: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(result_valid) |-> !busy) else $error("result dropped while busy");
endmodule

bind sit_target sit_target_props u_props (.mclk(mclk), .reset_n(reset_n),
  .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .meas_start(meas_start), .meas_cmd(meas_cmd), .meas_heat(meas_heat),
  .meas_done(meas_done), .meas_temp(meas_temp), .meas_hum(meas_hum), .busy(busy),
  .result_valid(result_valid));
`default_nettype wire

/* File: test/sit_ctl_model.sv */
// Behavioural two-wire bus controller: makes SCL, pulls SDA low or releases it.
// Assumes SDA is resolved outside with a pull-up; steps are whole clk cycles.
`default_nettype none
module sit_ctl_model (
  input  wire logic       clk,
  output logic            scl,
  output logic            pull,
  input  wire logic       sda,
  output logic            got_valid,
  output logic [8:0]      got_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Bus steps
  // ---------------------------------------------------------------
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    got_valid = 1'b0;
    got_data = 9'h000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // From a low clock this is a repeated start; SCL never pulses between frames.
  task automatic start();
    if (!scl) begin
      pull <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
    end
    pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    pull <= 1'b0;
    tick(6);
  endtask
  // A read sends all ones; got_data is the byte seen on the wire and the ninth bit.
  task automatic xfer(input logic [7:0] tx, input logic mack);
    logic [8:0] bits;
    logic [8:0] seen;
    bits = {tx, ~mack};
    for (int i = 8; i >= 0; i--) begin
      pull <= ~bits[i];
      tick(2);
      scl <= 1'b1;
      tick(2);
      seen[i] = sda;
      tick(2);
      scl <= 1'b0;
      tick(2);
    end
    pull <= 1'b0;
    got_data <= seen;
    got_valid <= 1'b1;
    tick(1);
    got_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/sit_target_test.sv */
// Self-checking bench for the sensor two-wire target with a controller model.
// Assumes sit_ctl_model and the bound checker are compiled before this file.
`include "sit_cfg.svh"
`default_nettype none
module sit_target_test;
  import sit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
  logic        mclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        meas_done = 1'b0;
  logic [15:0] meas_temp = 16'h0000;
  logic [15:0] meas_hum = 16'h0000;
  logic        scl, pull, got_valid, sda_o, sda_oe, meas_start, meas_heat, busy, result_valid;
  logic [8:0]  got_data;
  logic [7:0]  meas_cmd;
  logic        prev_start = 1'b0;
  logic [8:0]  exp_rd[$];
  logic [8:0]  exp_cmd[$];
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // The pull-up makes a released line read high; where the target drives, the
  // line shows sda_o, so a high drive shows up as a missing acknowledge.
  wire logic   sda = ~pull & (sda_oe ? sda_o : 1'b1);

  always #50 mclk = ~mclk;
  initial #13 forever #32 link_clk = ~link_clk;

  sit_target dut (.mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .meas_start(meas_start),
    .meas_cmd(meas_cmd), .meas_heat(meas_heat), .meas_done(meas_done),
    .meas_temp(meas_temp), .meas_hum(meas_hum), .busy(busy), .result_valid(result_valid));
  sit_ctl_model ctl (.clk(mclk), .scl(scl), .pull(pull), .sda(sda),
    .got_valid(got_valid), .got_data(got_data));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] tx, input logic mack, input logic [8:0] e);
    exp_rd.push_back(e);
    ctl.xfer(tx, mack);
  endtask

  task automatic hdr(input logic [6:0] a, input logic rd, input logic nak);
    ctl.start();
    put({a, rd}, 1'b0, {a, rd, nak});
  endtask

  task automatic cmd_w(input logic [6:0] a, input logic [7:0] c, input logic nh,
                       input logic nc);
    hdr(a, 1'b0, nh);
    if (!nh) begin
      put(c, 1'b0, {c, nc});
    end
    ctl.stop();
  endtask

  task automatic rd_nak();
    hdr(`SIT_ADDR, 1'b1, 1'b1);
    ctl.stop();
  endtask

  // Results are taken off the queues as they appear at the ports.
  always @(posedge mclk) begin
    logic [8:0] e;
    cycles++;
    if (got_valid) begin
      e = exp_rd.pop_front();
      `CHK("byte", e, got_data)
    end
    if (prev_start) begin
      e = exp_cmd.pop_front();
      `CHK("cmd", e, {meas_heat, meas_cmd})
    end
    prev_start <= meas_start;
    if (cycles > 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  cmds [9];
    logic [15:0] t, h;
    logic [47:0] rb;
    int          n;
    void'($urandom(32'hbfac));
    cmds = '{8'hfd, 8'hf6, 8'he0, 8'h39, 8'h32, 8'h2f, 8'h24, 8'h1e, 8'h15};
    `CHK("crc", 8'h92, crc_of(16'hbeef))
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    cmd_w(7'h45, 8'hfd, 1'b1, 1'b1);
    cmd_w(`SIT_ADDR, 8'h00, 1'b0, 1'b1);
    rd_nak();
    repeat (20) @(posedge mclk);
    `CHK("busy", 1'b0, busy)
    for (int i = 0; i < 9; i++) begin
      exp_cmd.push_back({1'(i > 2), cmds[i]});
      if (i == 0) hdr(`SIT_ADDR, 1'b0, 1'b0);
      cmd_w(`SIT_ADDR, cmds[i], 1'b0, 1'b0);
      for (int k = 0; k < 40 && busy !== 1'b1; k++) @(posedge mclk);
      `CHK("busy", 1'b1, busy)
      rd_nak();
      t = 16'($urandom);
      h = 16'($urandom);
      meas_temp <= t;
      meas_hum <= h;
      meas_done <= 1'b1;
      @(posedge mclk);
      meas_done <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK("valid", 1'b1, result_valid)
      rb = {t, crc_of(t), h, crc_of(h)};
      n = (i % 2 == 1) ? 2 : 6;
      hdr(`SIT_ADDR, 1'b1, 1'b0);
      for (int j = 0; j < n; j++) begin
        put(8'hff, j < n - 1, {rb[47 - 8 * j -: 8], j == n - 1});
      end
      ctl.stop();
      `CHK("valid", 1'b0, result_valid)
      rd_nak();
    end
    repeat (4) @(posedge mclk);
    `CHK("queued", 0, exp_rd.size() + exp_cmd.size())
    give_verdict();
  end
endmodule
`default_nettype wire
